// [hdl/atp_pkg.sv]
// Constants for the asynchronous timer clocking and prescaler block
package atp_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_COUNT    = 8'h00;
  localparam logic [7:0] OFS_CMP_A    = 8'h04;
  localparam logic [7:0] OFS_CMP_B    = 8'h08;
  localparam logic [7:0] OFS_CTL_A    = 8'h0C;
  localparam logic [7:0] OFS_CTL_B    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] OFS_FLAGS    = 8'h1C;
  localparam logic [7:0] OFS_GEN_CTL  = 8'h20;

  // ==========================================================
  // Field positions
  localparam int STS_ASYNC_SEL  = 0;
  localparam int STS_BUSY_LSB   = 1;
  localparam int CTLA_TOG_A     = 0;
  localparam int CTLA_TOG_B     = 1;
  localparam int CTLB_CS_LSB    = 0;
  localparam int GEN_PSR        = 0;
  localparam int FLG_OVF        = 0;
  localparam int FLG_CMP_A      = 1;
  localparam int FLG_CMP_B      = 2;

  // ==========================================================
  // Holding register slots
  localparam int NUM_HOLD     = 5;
  localparam int SLOT_COUNT   = 0;
  localparam int SLOT_CMP_A   = 1;
  localparam int SLOT_CMP_B   = 2;
  localparam int SLOT_CTL_A   = 3;
  localparam int SLOT_CTL_B   = 4;

  // ==========================================================
  // Reset values and cycle counts
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] XFER_EDGES   = 2'h2;
  localparam logic [2:0] HALT_CYCLES  = 3'h4;
  localparam int         FLAG_SYNC_CYC = 3;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  // ==========================================================
  // Prescaler tap masks
  localparam logic [9:0] MASK_DIV1    = 10'h000;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV32   = 10'h01F;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV128  = 10'h07F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  // ==========================================================
  // Sleep mode codes
  localparam logic [2:0] SLP_IDLE     = 3'h0;
  localparam logic [2:0] SLP_NOISE    = 3'h1;
  localparam logic [2:0] SLP_PDOWN    = 3'h2;
  localparam logic [2:0] SLP_PSAVE    = 3'h3;
  localparam logic [2:0] SLP_STBY     = 3'h6;
  localparam logic [2:0] SLP_EXT_STBY = 3'h7;

endpackage : atp_pkg

// [hdl/atp_hold_xfer.sv]
// Holding register with update-busy flag for one timer-domain register
`timescale 1ns/1ps
module atp_hold_xfer
  import atp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             async_sel,
  input  wire logic             osc_rise,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  load,
  output logic [WIDTH-1:0]      hold_data,
  output logic                  busy
);

  if (WIDTH < 1) begin : g_width_check
    $error("atp_hold_xfer: WIDTH must be positive");
  end

  logic [WIDTH-1:0] hold_reg;
  logic             pend_reg;
  logic [1:0]       edge_reg;
  logic             done_reg;
  logic             busy_reg;

  // ==========================================================
  // Transfer on second oscillator edge, or at once when synchronous
  assign load      = pend_reg & ~wr_en & (~async_sel | (osc_rise & (edge_reg == XFER_EDGES - 2'h1)));
  assign hold_data = hold_reg;
  assign busy      = busy_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= '0;
      pend_reg <= 1'b0;
      edge_reg <= 2'h0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      done_reg <= load;
      if (wr_en) begin
        hold_reg <= wr_data;
        pend_reg <= 1'b1;
        edge_reg <= 2'h0;
        busy_reg <= 1'b1;
      end else begin
        if (load) begin
          pend_reg <= 1'b0;
        end else if (pend_reg && osc_rise) begin
          edge_reg <= edge_reg + 2'h1;
        end
        if (done_reg && !pend_reg) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  AST_LOAD_TWO_EDGES: assert property (@(posedge aclk) disable iff (!aresetn)
    load && async_sel |-> osc_rise && edge_reg == 2'h1)
    else $error("transfer before second oscillator edge");

  AST_BUSY_ON_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en |=> busy && (!async_sel || !load) ##1 busy)
    else $error("busy flag not raised by write");

endmodule : atp_hold_xfer

// [hdl/atp_timer_async.sv]
// Asynchronous clocking, write transfer and prescaler of the 8-bit timer
//
// Operation
// - Writes reach destination after two oscillator edges, at once when synchronous
// - Five registers each own a holding register
// - Status shows one update-busy flag per holding
// - Compare suppressed while count or compare pending
// - Oscillator runs only while async selected, except in power-down, standby
// - Wake-up starts on next timer clock
// - Core halted four cycles after timer wake
// - Count copy refreshed each rising oscillator edge
// - Flags reach core after three cycles plus tick
// - Compare pin changes in timer clock domain
// - Source is core clock unless async selected
// - Async select detaches both oscillator pins
// - Prescaler offers 1,8,32,64,128,256,1024, stop
// - Prescaler reset bit clears the prescaler
`timescale 1ns/1ps
module atp_timer_async
  import atp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_in_pin,
  input  wire logic        sleep_active,
  input  wire logic [2:0]  sleep_mode,
  output logic             osc_enable,
  output logic             osc_pins_detached,
  output logic             compare_out_a,
  output logic             compare_out_b,
  output logic             wake_req,
  output logic             cpu_halt
);

  // ==========================================================
  // Bus slave state
  logic [7:0]  aw_addr_reg;
  logic        aw_full_reg;
  logic [7:0]  w_data_reg;
  logic        w_strb_reg;
  logic        w_full_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  wire wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire wr_byte = wr_fire & w_strb_reg;
  wire wr_hit  = (aw_addr_reg <= OFS_GEN_CTL) & (aw_addr_reg[1:0] == 2'h0);
  wire rd_fire = s_axi_arvalid & ~rvalid_reg;
  wire rd_hit  = (s_axi_araddr <= OFS_GEN_CTL) & (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      aw_full_reg <= 1'b0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
        w_full_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Oscillator pin synchroniser and edge detect
  logic osc_meta_reg;
  logic osc_sync_reg;
  logic osc_prev_reg;
  wire  osc_rise = osc_sync_reg & ~osc_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= osc_in_pin;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // ==========================================================
  // Control and status registers
  logic       async_sel_reg;
  logic [2:0] irq_en_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic       psr_reg;

  wire sel_status = wr_byte & (aw_addr_reg == OFS_STATUS);
  wire sel_irq_en = wr_byte & (aw_addr_reg == OFS_IRQ_EN);
  wire sel_flags  = wr_byte & (aw_addr_reg == OFS_FLAGS);
  wire sel_gen    = wr_byte & (aw_addr_reg == OFS_GEN_CTL);

  // Timer source is core clock until async select is set
  wire src_tick = async_sel_reg ? osc_rise : 1'b1;
  assign osc_pins_detached = async_sel_reg;
  wire deep_sleep = sleep_active & ((sleep_mode == SLP_PDOWN) | (sleep_mode == SLP_STBY));
  assign osc_enable = async_sel_reg & ~deep_sleep;

  // ==========================================================
  // Holding registers, one per destination
  logic [NUM_HOLD-1:0] hold_wr;
  logic [NUM_HOLD-1:0] hold_load;
  logic [NUM_HOLD-1:0] hold_busy;
  logic [7:0]          hold_data [NUM_HOLD];
  logic [7:0]          dest_reg  [NUM_HOLD];
  logic [7:0]          count_reg;
  logic [7:0]          count_copy_reg;
  logic                timer_tick;

  assign hold_wr[SLOT_COUNT] = wr_byte & (aw_addr_reg == OFS_COUNT);
  assign hold_wr[SLOT_CMP_A] = wr_byte & (aw_addr_reg == OFS_CMP_A);
  assign hold_wr[SLOT_CMP_B] = wr_byte & (aw_addr_reg == OFS_CMP_B);
  assign hold_wr[SLOT_CTL_A] = wr_byte & (aw_addr_reg == OFS_CTL_A);
  assign hold_wr[SLOT_CTL_B] = wr_byte & (aw_addr_reg == OFS_CTL_B);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_HOLD; gi++) begin : g_hold
      atp_hold_xfer #(.WIDTH(8)) u_hold (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .async_sel (async_sel_reg),
        .osc_rise  (osc_rise),
        .wr_en     (hold_wr[gi]),
        .wr_data   (w_data_reg),
        .load      (hold_load[gi]),
        .hold_data (hold_data[gi]),
        .busy      (hold_busy[gi])
      );
      if (gi == SLOT_COUNT) begin : g_cnt
        assign dest_reg[gi] = count_reg;
      end else begin : g_dst
        logic [7:0] val_reg;
        assign dest_reg[gi] = val_reg;
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            val_reg <= RST_BYTE;
          end else if (hold_load[gi]) begin
            val_reg <= hold_data[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Prescaler
  logic [9:0] presc_reg;
  logic [9:0] presc_mask;
  wire  [2:0] clk_sel = dest_reg[SLOT_CTL_B][CTLB_CS_LSB +: 3];

  assign presc_mask = (clk_sel == 3'h1) ? MASK_DIV1 :
                      (clk_sel == 3'h2) ? MASK_DIV8 :
                      (clk_sel == 3'h3) ? MASK_DIV32 :
                      (clk_sel == 3'h4) ? MASK_DIV64 :
                      (clk_sel == 3'h5) ? MASK_DIV128 :
                      (clk_sel == 3'h6) ? MASK_DIV256 : MASK_DIV1024;
  assign timer_tick = src_tick & (clk_sel != 3'h0) & ((presc_reg & presc_mask) == presc_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= 10'h000;
    end else if (psr_reg) begin
      presc_reg <= 10'h000;
    end else if (src_tick) begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  // ==========================================================
  // Counter, compare and compare pins
  wire cmp_a_evt = timer_tick & (count_reg == dest_reg[SLOT_CMP_A])
                   & ~hold_busy[SLOT_COUNT] & ~hold_busy[SLOT_CMP_A];
  wire cmp_b_evt = timer_tick & (count_reg == dest_reg[SLOT_CMP_B])
                   & ~hold_busy[SLOT_COUNT] & ~hold_busy[SLOT_CMP_B];
  wire ovf_evt   = timer_tick & (count_reg == 8'hFF);
  logic cmp_out_a_reg;
  logic cmp_out_b_reg;
  assign compare_out_a = cmp_out_a_reg;
  assign compare_out_b = cmp_out_b_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg      <= RST_BYTE;
      count_copy_reg <= RST_BYTE;
      cmp_out_a_reg  <= 1'b0;
      cmp_out_b_reg  <= 1'b0;
    end else begin
      if (hold_load[SLOT_COUNT]) begin
        count_reg <= hold_data[SLOT_COUNT];
      end else if (timer_tick) begin
        count_reg <= count_reg + 8'h01;
      end
      if (src_tick) begin
        count_copy_reg <= count_reg;
      end
      if (cmp_a_evt && dest_reg[SLOT_CTL_A][CTLA_TOG_A]) begin
        cmp_out_a_reg <= ~cmp_out_a_reg;
      end
      if (cmp_b_evt && dest_reg[SLOT_CTL_A][CTLA_TOG_B]) begin
        cmp_out_b_reg <= ~cmp_out_b_reg;
      end
    end
  end

  // ==========================================================
  // Flag synchronisation, wake-up and halt
  logic [2:0] evt_pipe_reg [FLAG_SYNC_CYC-1];
  logic       wake_reg;
  logic [2:0] halt_reg;
  wire  [2:0] evt_now  = {cmp_b_evt, cmp_a_evt, ovf_evt};
  wire  [2:0] flag_clr = sel_flags ? w_data_reg[2:0] : 3'h0;
  wire        irq_pend = |(flags_reg & irq_en_reg);
  wire        wake_now = sleep_active & irq_pend & src_tick & ~wake_reg;

  assign flags_next = (flags_reg & ~flag_clr) | evt_pipe_reg[FLAG_SYNC_CYC-2];
  assign wake_req   = wake_reg;
  assign cpu_halt   = (halt_reg != 3'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      async_sel_reg <= 1'b0;
      irq_en_reg    <= 3'h0;
      flags_reg     <= 3'h0;
      psr_reg       <= 1'b0;
      wake_reg      <= 1'b0;
      halt_reg      <= 3'h0;
      for (int i = 0; i < FLAG_SYNC_CYC - 1; i++) begin
        evt_pipe_reg[i] <= 3'h0;
      end
    end else begin
      evt_pipe_reg[0] <= evt_now;
      for (int i = 1; i < FLAG_SYNC_CYC - 1; i++) begin
        evt_pipe_reg[i] <= evt_pipe_reg[i-1];
      end
      flags_reg <= flags_next;
      psr_reg   <= sel_gen & w_data_reg[GEN_PSR];
      wake_reg  <= wake_now;
      if (sel_status) begin
        async_sel_reg <= w_data_reg[STS_ASYNC_SEL];
      end
      if (sel_irq_en) begin
        irq_en_reg <= w_data_reg[2:0];
      end
      if (wake_now) begin
        halt_reg <= HALT_CYCLES;
      end else if (halt_reg != 3'h0) begin
        halt_reg <= halt_reg - 3'h1;
      end
    end
  end

  // ==========================================================
  // Read path
  wire [7:0] rd_byte =
    (s_axi_araddr == OFS_COUNT)  ? count_copy_reg :
    (s_axi_araddr == OFS_CMP_A)  ? dest_reg[SLOT_CMP_A] :
    (s_axi_araddr == OFS_CMP_B)  ? dest_reg[SLOT_CMP_B] :
    (s_axi_araddr == OFS_CTL_A)  ? dest_reg[SLOT_CTL_A] :
    (s_axi_araddr == OFS_CTL_B)  ? dest_reg[SLOT_CTL_B] :
    (s_axi_araddr == OFS_STATUS) ? {2'h0, hold_busy, async_sel_reg} :
    (s_axi_araddr == OFS_IRQ_EN) ? {5'h00, irq_en_reg} :
    (s_axi_araddr == OFS_FLAGS)  ? {5'h00, flags_reg} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_hit ? rd_byte : 8'h00};
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  AST_SRC_DEFAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    !async_sel_reg && !psr_reg |=> presc_reg == $past(presc_reg) + 10'h001)
    else $error("synchronous source does not advance every cycle");

  AST_CMP_SUPPRESS: assert property (@(posedge aclk) disable iff (!aresetn)
    (hold_busy[SLOT_COUNT] || hold_busy[SLOT_CMP_A]) |-> !cmp_a_evt)
    else $error("compare fired during pending write");

  AST_FLAG_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_evt |-> ##3 flags_reg[FLG_OVF])
    else $error("overflow flag latency wrong");

  AST_FLAG_NOT_EARLY: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_evt && !flags_reg[FLG_OVF] |=> !flags_reg[FLG_OVF] ##1 !flags_reg[FLG_OVF])
    else $error("overflow flag visible too early");

  AST_HALT_FOUR: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_now |=> cpu_halt [*4] ##1 (!cpu_halt || wake_reg))
    else $error("halt not four cycles");

  AST_OSC_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
    async_sel_reg && sleep_active && sleep_mode == SLP_PSAVE |-> osc_enable)
    else $error("oscillator stopped in power-save");

  AST_PSR_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_gen && w_data_reg[GEN_PSR] |=> ##1 presc_reg == 10'h000)
    else $error("prescaler not reset");

  AST_COPY_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    async_sel_reg && !osc_rise |=> $stable(count_copy_reg))
    else $error("count copy changed without oscillator edge");

  AST_DETACH: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(async_sel_reg) |-> osc_pins_detached && $past(sel_status))
    else $error("pins not detached on async select");

endmodule : atp_timer_async

// [verification/atp_osc_model.sv]
// Oscillator pin model feeding the asynchronous timer clock input
`timescale 1ns/1ps
module atp_osc_model #(
  parameter int HALF = 5
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic osc_enable,
  output logic      osc_in_pin
);
  int cnt;
  // ==========================================================
  // Toggle slower than a quarter of the core clock, stand still when off
  always_ff @(posedge aclk) begin
    if (!aresetn || !osc_enable) begin
      cnt        <= 0;
      osc_in_pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt        <= 0;
      osc_in_pin <= !osc_in_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : atp_osc_model

// [verification/tb_async_timer_sync_prescaler.sv]
// Self-checking testbench for the asynchronous timer block
`timescale 1ns/1ps
module tb_async_timer_sync_prescaler;
  import atp_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic osc, slp = 0, oen, det, cpa, cpb, wk, hlt;
  logic [2:0] smode = SLP_IDLE;
  int errors = 0, n_compared = 0;
  logic [1:0] r;
  logic [31:0] d;

  always #10 aclk = !aclk;

  atp_timer_async DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_in_pin(osc), .sleep_active(slp), .sleep_mode(smode),
    .osc_enable(oen), .osc_pins_detached(det), .compare_out_a(cpa),
    .compare_out_b(cpb), .wake_req(wk), .cpu_halt(hlt));

  atp_osc_model #(.HALF(5)) OSC (.aclk(aclk), .aresetn(aresetn), .osc_enable(oen),
    .osc_in_pin(osc));

  // ==========================================================
  // Bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin ad = 1; awvalid <= 0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask : rd

  task automatic wait_idle();
    int n;
    n = 0;
    do begin rd(OFS_STATUS, d, r); n++; end while (d[5:1] !== 5'h00 && n < 60);
    chk("busy", 32'h0, {26'h0, d[5:1], 1'b0});
  endtask : wait_idle

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(OFS_STATUS, d, r);
    chk("status", 32'h0, d);
    chk("detach", 32'h0, {31'h0, det});
  endtask : t_reset

  task automatic t_sync();
    wr(OFS_CTL_B, 32'h3, r);
    wait_idle();
    rd(OFS_CTL_B, d, r);
    chk("ctl_b", 32'h3, d);
    wr(OFS_GEN_CTL, 32'h1, r);
    rd(OFS_GEN_CTL, d, r);
    chk("psr", 32'h0, d);
  endtask : t_sync

  task automatic t_wake();
    logic p;
    int n;
    wr(OFS_CTL_A, 32'h1, r);
    wr(OFS_CMP_A, 32'h40, r);
    wr(OFS_CTL_B, 32'h1, r);
    wait_idle();
    p = cpa;
    n = 0;
    do begin @(posedge aclk); n++; end while (cpa === p && n < 300);
    chk("cmp_pin", {31'h0, !p}, {31'h0, cpa});
    repeat (4) @(posedge aclk);
    rd(OFS_FLAGS, d, r);
    chk("flag_a", 32'h2, d & 32'h2);
    wr(OFS_FLAGS, 32'h7, r);
    wr(OFS_IRQ_EN, 32'h2, r);
    slp <= 1;
    smode <= SLP_PSAVE;
    n = 0;
    do begin @(posedge aclk); n++; end while (wk !== 1'b1 && n < 300);
    chk("wake", 32'h1, {31'h0, wk});
    slp <= 0;
    n = 1;
    @(posedge aclk);
    chk("wake_pulse", 32'h0, {31'h0, wk});
    while (hlt === 1'b1 && n < 8) begin n++; @(posedge aclk); end
    chk("halt", {29'h0, HALT_CYCLES}, n);
    smode <= SLP_IDLE;
  endtask : t_wake

  task automatic t_async();
    wr(OFS_IRQ_EN, 32'h0, r);
    wr(OFS_STATUS, 32'h1, r);
    chk("detach", 32'h1, {31'h0, det});
    chk("osc_en", 32'h1, {31'h0, oen});
    repeat (20) @(posedge aclk);
    wr(OFS_CMP_A, 32'h5A, r);
    wr(OFS_COUNT, 32'h10, r);
    rd(OFS_STATUS, d, r);
    chk("busy2", 32'h7, d & 32'h7);
    wait_idle();
    wr(OFS_FLAGS, 32'h7, r);
    rd(OFS_CMP_A, d, r);
    chk("cmp_a", 32'h5A, d);
    wr(OFS_CTL_A, 32'h1, r);
    wait_idle();
    rd(OFS_COUNT, d, r);
    chk("count_adv", 32'h1, {31'h0, d[7:0] > 8'h10});
    slp <= 1;
    smode <= SLP_PDOWN;
    @(posedge aclk);
    chk("osc_pd", 32'h0, {31'h0, oen});
    smode <= SLP_PSAVE;
    @(posedge aclk);
    chk("osc_ps", 32'h1, {31'h0, oen});
    slp <= 0;
    wr(OFS_CTL_B, 32'h1, r);
  endtask : t_async

  task automatic t_unmapped();
    rd(8'h24, d, r);
    chk("rresp", {30'h0, RESP_DECERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    wr(8'h24, 32'hFF, r);
    chk("bresp", {30'h0, RESP_DECERR}, {30'h0, r});
  endtask : t_unmapped

  // ==========================================================
  // Verdict and main sequence
  task automatic results();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_sync();
    t_unmapped();
    t_wake();
    t_async();
    results();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end
endmodule : tb_async_timer_sync_prescaler
